/* dv/saspe_exec_sva.sv */
// Checker for the sequencer's memory cycles and completion pulses.
// Assumes it is bound to saspe_exec and shares its clock and reset.
`timescale 1ns/10ps
module saspe_exec_sva (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic        fetch_cycle,
   input wire logic        instr_done,
   input wire logic        unsupported_op,
   input wire logic [15:0] stack_pointer
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Every write burst is two 3-state cycles back to back
   property p_wr_burst;
      $rose(mem_wr) |-> mem_wr [*6] ##1 !mem_wr;
   endproperty
   a_wr_burst: assert property (p_wr_burst) else $error("write burst length");
   property p_push_top;
      $rose(mem_wr) && $past(fetch_cycle) |-> mem_addr == $past(stack_pointer, 5) - 16'h0001;
   endproperty
   a_push_top: assert property (p_push_top) else $error("push first address");
   property p_push_dn;
      $rose(mem_wr) && $past(fetch_cycle) |-> ##3 mem_addr == $past(mem_addr, 3) - 16'h0001;
   endproperty
   a_push_dn: assert property (p_push_dn) else $error("push second address");
   // Stores follow operand reads, pushes follow a fetch
   property p_store_up;
      $rose(mem_wr) && !$past(fetch_cycle) |-> ##3 mem_addr == $past(mem_addr, 3) + 16'h0001;
   endproperty
   a_store_up: assert property (p_store_up) else $error("store address step");
   property p_rd_up;
      $fell(fetch_cycle) && mem_rd |-> ##3 mem_addr == $past(mem_addr, 3) + 16'h0001;
   endproperty
   a_rd_up: assert property (p_rd_up) else $error("read address step");
   property p_rd_burst;
      $fell(fetch_cycle) && mem_rd |-> (mem_rd && !fetch_cycle) [*6];
   endproperty
   a_rd_burst: assert property (p_rd_burst) else $error("read burst length");
   property p_done_fetch;
      instr_done |-> fetch_cycle && !mem_wr;
   endproperty
   a_done_fetch: assert property (p_done_fetch) else $error("done outside fetch");
   property p_unsup;
      unsupported_op |-> instr_done;
   endproperty
   a_unsup: assert property (p_unsup) else $error("refusal without done");
   property p_fetch_len;
      $rose(fetch_cycle) |-> fetch_cycle [*4];
   endproperty
   a_fetch_len: assert property (p_fetch_len) else $error("fetch too short");
   c_push: cover property ($rose(mem_wr) && $past(fetch_cycle));
   c_store: cover property ($rose(mem_wr) && !$past(fetch_cycle));
   c_refuse: cover property (unsupported_op);
endmodule // saspe_exec_sva
bind saspe_exec saspe_exec_sva i_sva (.mclk, .srst, .mem_addr, .mem_rd, .mem_wr,
   .fetch_cycle, .instr_done, .unsupported_op, .stack_pointer);

/* dv/saspe_mem_model.sv */
// Byte-wide memory holding program and stack for the sequencer bench.
// Assumes address and data stand unchanged through each write cycle.
`timescale 1ns/10ps
module saspe_mem_model (
   input wire logic        mclk,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   output logic     [7:0]  mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_rd = 8'h00;
   // Idle bus shows the inverse of the last byte, never a stale copy
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_rd;
   always @(posedge mclk) begin
      if (mem_rd) last_rd <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wdata;
   end
endmodule // saspe_mem_model

/* dv/test_stack_and_sp_load_exec.sv */
// Self-checking bench: programs run from the memory model after reset.
// Assumes three leading unhandled opcodes give time to seed registers.
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_stack_and_sp_load_exec;
   import saspe_pkg::*;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [15:0] mem_addr, stack_pointer, seed_data = 16'h0000, view_data, pc;
   logic [7:0]  mem_wdata, mem_rdata;
   logic        mem_rd, mem_wr, instr_done, unsup, seed_en = 1'b0;
   logic [2:0]  seed_sel = 3'h0, view_sel = 3'h0;
   int          fails = 0, checks_done = 0, cyc = 0, tmo = 0;
   int          done_t[$];
   logic [15:0] sp_log[$];
   logic [15:0] pc_log[$];
   logic        unsup_log[$];
   saspe_exec i_dut (.mclk, .srst, .mem_addr, .mem_wdata, .mem_rdata, .mem_rd, .mem_wr,
      .fetch_cycle(), .instr_done, .unsupported_op(unsup), .stack_pointer, .program_counter(pc),
      .seed_en, .seed_sel, .seed_data, .view_sel, .view_data);
   saspe_mem_model i_mem (.mclk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= srst ? 0 : cyc + 1;
      tmo <= tmo + 1;
      if (tmo == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   always @(negedge mclk) begin
      if (!srst && instr_done === 1'b1) begin
         done_t.push_back(cyc);
         sp_log.push_back(stack_pointer);
         pc_log.push_back(pc);
         unsup_log.push_back(unsup);
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic start(input logic [7:0] prog[$], input logic [15:0] regs[6]);
      srst <= 1'b1;
      repeat (10) @(posedge mclk);
      for (int a = 0; a < 65536; a++) i_mem.mem[a] = 8'h00;
      foreach (prog[i]) i_mem.mem[i + 3] = prog[i];
      done_t.delete();
      sp_log.delete();
      pc_log.delete();
      unsup_log.delete();
      srst <= 1'b0;
      for (int s = 0; s < 6; s++) begin
         @(posedge mclk);
         seed_en <= 1'b1;
         seed_sel <= 3'(s);
         seed_data <= regs[s];
      end
      @(posedge mclk);
      seed_en <= 1'b0;
   endtask
   // Completion times are cumulative states after the three leading fetches
   task automatic expect_ops(input int d[$]);
      int t;
      int k;
      t = 12;
      k = 0;
      while (done_t.size() < d.size() + 3 && k < 400) begin
         @(posedge mclk);
         k++;
      end
      `CHK(done_t.size(), d.size() + 3)
      if (done_t.size() == d.size() + 3) foreach (d[i]) begin
         t += d[i];
         `CHK(done_t[i + 3], t)
      end
   endtask
   task automatic view_chk(input logic [2:0] s, input logic [15:0] exp);
      @(posedge mclk);
      view_sel <= s;
      @(posedge mclk);
      @(negedge mclk);
      `CHK(view_data, exp)
      // Hand back on a rising edge so later drives stay edge aligned
      @(posedge mclk);
   endtask
   task automatic t_store;
      start('{8'hFD, 8'h22, 8'h38, 8'h88, 8'hFD, 8'h22, 8'hFF, 8'hFF,
         8'hDD, 8'h22, 8'h10, 8'h20},
         '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h5A30, 16'h4174});
      expect_ops('{20, 20, 20});
      `CHK(pc_log[3], 16'h0007)
      `CHK(pc_log[5], 16'h000F)
      `CHK(i_mem.mem[16'h2010], 8'h30)
      `CHK(i_mem.mem[16'h2011], 8'h5A)
      `CHK(i_mem.mem[16'h8838], 8'h74)
      `CHK(i_mem.mem[16'h8839], 8'h41)
      `CHK(i_mem.mem[16'hFFFF], 8'h74)
      `CHK(i_mem.mem[16'h0000], 8'h41)
   endtask
   task automatic t_ldsp;
      start('{8'h22, 8'hF9, 8'hDD, 8'hF9, 8'hFD, 8'hF9},
         '{16'h0000, 16'h0000, 16'h442E, 16'h0000, 16'h98DA, 16'hA227});
      expect_ops('{4, 6, 10, 10});
      `CHK(sp_log[3], 16'h0000)
      `CHK(sp_log[4], 16'h442E)
      `CHK(sp_log[5], 16'h98DA)
      `CHK(sp_log[6], 16'hA227)
      `CHK(unsup_log[3], 1'b1)
      `CHK(unsup_log[6], 1'b0)
      `CHK(pc_log[6], 16'h0009)
   endtask
   task automatic t_push_pop;
      logic [15:0] v[6];
      v = '{16'h1122, 16'h3344, 16'h1007, 16'h7788, 16'h99AA, 16'hBBCC};
      start('{8'hF9, 8'hC5, 8'hD5, 8'hE5, 8'hF5, 8'hDD, 8'hE5, 8'hFD, 8'hE5, 8'hC1,
         8'hD1, 8'hE1, 8'hF1, 8'hDD, 8'hE1, 8'hFD, 8'hE1}, v);
      expect_ops('{6, 11, 11, 11, 11, 15, 15, 10, 10, 10, 10, 14, 14});
      for (int k = 0; k < 6; k++) begin
         `CHK(i_mem.mem[16'h1006 - 16'(2 * k)], v[k][15:8])
         `CHK(i_mem.mem[16'h1005 - 16'(2 * k)], v[k][7:0])
         view_chk(3'(k), v[5 - k]);
      end
      `CHK(sp_log[9], 16'h0FFB)
      `CHK(sp_log[15], 16'h1007)
   endtask
   task automatic t_wrap;
      start('{8'hF9, 8'hC5, 8'hD1},
         '{16'hABCD, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000});
      expect_ops('{6, 11, 10});
      `CHK(i_mem.mem[16'h0000], 8'hAB)
      `CHK(i_mem.mem[16'hFFFF], 8'hCD)
      `CHK(sp_log[4], 16'hFFFF)
      `CHK(sp_log[5], 16'h0001)
      view_chk(SASPE_SEL_SECOND, 16'hABCD);
   endtask
   initial begin
      t_store();
      t_ldsp();
      t_push_pop();
      t_wrap();
      report_and_stop();
   end
endmodule // test_stack_and_sp_load_exec

/* verilog/saspe_exec.sv */
// Sequencer for the index store, stack pointer loads, pushes and pops.
// Assumes memory on the same clock that presents read data at state index 1
// of every read cycle and takes write data while mem_wr is high.
`timescale 1ns/10ps
// Summary of operation
// - Prefix FD then 22 and two address bytes stores index_reg_y low at imm_addr, high at +1.
// - That store takes six machine cycles of 4, 4, 3, 3, 3 and 3 states.
// - The first operand byte after the opcodes is the low byte of imm_addr, the next the high.
// - F9 copies pointer_pair into stack_pointer in one machine cycle of 6 states.
// - DD then F9 copies index_reg_x into stack_pointer in cycles of 4 and 6 states.
// - FD then F9 copies index_reg_y into stack_pointer with the same timing.
// - Push 11qq0101 picks count, second, pointer or accum_flags pair by push_pair_select.
// - A pair push decrements, writes the high byte, decrements, writes low; 5, 3, 3 states.
// - DD then E5 pushes index_reg_x high byte first in cycles of 4, 5, 3 and 3 states.
// - FD then E5 pushes index_reg_y with the same order and timing.
// - Pop 11qq0001 reads low at stack_pointer, increments, reads high, increments again.
// - DD then E1 pops index_reg_x low then high in cycles of 4, 4, 3 and 3 states.
// - Popping index_reg_y uses the same order, double increment and 14 states.
// - stack_pointer is a 16-bit register holding the address of the top stack byte.
// - None of these operations alters a condition flag beyond a popped value.
module saspe_exec
   import saspe_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        srst,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic             fetch_cycle,
   output logic             instr_done,
   output logic             unsupported_op,
   output logic [15:0]      stack_pointer,
   output logic [15:0]      program_counter,
   input  wire logic        seed_en,
   input  wire logic [2:0]  seed_sel,
   input  wire logic [15:0] seed_data,
   input  wire logic [2:0]  view_sel,
   output logic [15:0]      view_data
);

   saspe_phase_t phase;
   saspe_pfx_t   prefix;
   logic [2:0]   tstate;
   logic [7:0]   opcode;
   logic [7:0]   data_lo;
   logic [15:0]  imm_addr;

   function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
      step16 = up ? v + SASPE_ONE : v - SASPE_ONE;
   endfunction

   // Opcode decode
   wire        is_pfx_x   = (opcode == SASPE_PFX_X);
   wire        is_pfx_y   = (opcode == SASPE_PFX_Y);
   wire        is_push    = ((opcode & SASPE_PUSH_MASK) == SASPE_PUSH_PAT);
   wire        is_pop     = ((opcode & SASPE_PUSH_MASK) == SASPE_POP_PAT);
   wire        is_ldsp    = (opcode == SASPE_OP_LDSP);
   wire        is_store   = (opcode == SASPE_OP_STABS) && (prefix != saspe_pfx_none);
   wire [1:0]  pair_field = opcode[SASPE_QQ_LSB +: 2];

   // Prefixed forms reuse the pair-10 slot for the index register
   wire [2:0]  sel_index  = (prefix == saspe_pfx_y) ? SASPE_SEL_IDX_Y : SASPE_SEL_IDX_X;
   wire [2:0]  operand_sel =
      (prefix != saspe_pfx_none)   ? sel_index :
      is_ldsp                      ? SASPE_SEL_PTR :
                                     {1'b0, pair_field};

   // Machine cycle length; opcode is valid from state 2 onward
   wire [2:0]  fetch_len  = is_ldsp ? SASPE_T_FETCH_SP :
                            is_push ? SASPE_T_FETCH_PU :
                                      SASPE_T_FETCH;
   wire [2:0]  cycle_len  = (phase == saspe_ph_fetch) ? fetch_len : SASPE_T_MEM;
   wire        cycle_end  = (tstate == cycle_len - 3'h1);
   wire        sample     = (tstate == SASPE_T_SAMPLE);

   wire        phase_rd   = (phase == saspe_ph_fetch) || (phase == saspe_ph_rd_lo) ||
                            (phase == saspe_ph_rd_hi);
   wire        operand_rd = is_store && ((phase == saspe_ph_rd_lo) ||
                                         (phase == saspe_ph_rd_hi));

   logic [15:0] operand_word;
   logic [7:0]  mem_rdata_q;
   wire  [15:0] imm_next = step16(imm_addr, 1'b1);

   // Writes into the register file: pop completion, else the seed port
   wire        pop_write  = (phase == saspe_ph_rd_hi) && !is_store && cycle_end;
   wire        rf_wr_en   = pop_write || seed_en;
   wire [2:0]  rf_wr_sel  = pop_write ? operand_sel : seed_sel;
   // Flags live only in accum_flags_pair; nothing here computes them
   wire [15:0] rf_wr_data = pop_write ? {mem_rdata_q, data_lo} : seed_data;


   saspe_regfile #(
      .WIDTH (16),
      .DEPTH (SASPE_NUM_REGS)
   ) u_regs (
      .mclk     (mclk),
      .srst     (srst),
      .wr_en    (rf_wr_en),
      .wr_sel   (rf_wr_sel),
      .wr_data  (rf_wr_data),
      .rd_sel   (operand_sel),
      .rd_data  (operand_word),
      .dbg_sel  (view_sel),
      .dbg_data (view_data)
   );

   // Bus drive decoded from state registers only
   always_comb begin
      mem_addr  = program_counter;
      mem_wdata = operand_word[7:0];
      unique case (phase)
         saspe_ph_fetch:   mem_addr = program_counter;
         saspe_ph_rd_lo,
         saspe_ph_rd_hi:   mem_addr = is_store ? program_counter : stack_pointer;
         saspe_ph_push_hi: begin
            mem_addr  = stack_pointer;
            mem_wdata = operand_word[15:8];
         end
         saspe_ph_push_lo: mem_addr = stack_pointer;
         saspe_ph_st_lo:   mem_addr = imm_addr;
         saspe_ph_st_hi: begin
            mem_addr  = imm_next;
            mem_wdata = operand_word[15:8];
         end
      endcase
   end

   assign mem_rd      = phase_rd;
   assign mem_wr      = !phase_rd;
   assign fetch_cycle = (phase == saspe_ph_fetch);

   // Clock state counter
   always_ff @(posedge mclk) begin
      if (srst || cycle_end) begin
         tstate <= '0;
      end else begin
         tstate <= tstate + 3'h1;
      end
   end

   // Read data capture at the sample state
   always_ff @(posedge mclk) begin
      if (srst) begin
         opcode      <= '0;
         mem_rdata_q <= '0;
      end else if (sample && phase_rd) begin
         if (phase == saspe_ph_fetch) begin
            opcode <= mem_rdata;
         end
         mem_rdata_q <= mem_rdata;
      end
   end

   // Program counter steps past each opcode and operand byte
   always_ff @(posedge mclk) begin
      if (srst) begin
         program_counter <= SASPE_RST_WORD;
      end else if (cycle_end && ((phase == saspe_ph_fetch) || operand_rd)) begin
         program_counter <= step16(program_counter, 1'b1);
      end
   end

   // Operand bytes: first low, second high
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_lo  <= '0;
         imm_addr <= SASPE_RST_WORD;
      end else if (cycle_end && (phase == saspe_ph_rd_lo)) begin
         data_lo <= mem_rdata_q;
      end else if (cycle_end && (phase == saspe_ph_rd_hi) && is_store) begin
         imm_addr <= {mem_rdata_q, data_lo};
      end
   end

   // Stack pointer: 16 bits, moved only by this sequencer
   always_ff @(posedge mclk) begin
      if (srst) begin
         stack_pointer <= SASPE_RST_WORD;
      end else if (cycle_end) begin
         unique case (phase)
            saspe_ph_fetch: begin
               if (is_ldsp) begin
                  stack_pointer <= operand_word;
               end else if (is_push) begin
                  stack_pointer <= step16(stack_pointer, 1'b0);
               end
            end
            saspe_ph_push_hi: stack_pointer <= step16(stack_pointer, 1'b0);
            saspe_ph_rd_lo,
            saspe_ph_rd_hi: begin
               if (!is_store) begin
                  stack_pointer <= step16(stack_pointer, 1'b1);
               end
            end
            default: stack_pointer <= stack_pointer;
         endcase
      end
   end

   // Instruction sequencing
   always_ff @(posedge mclk) begin
      if (srst) begin
         phase          <= saspe_ph_fetch;
         prefix         <= saspe_pfx_none;
         instr_done     <= 1'b0;
         unsupported_op <= 1'b0;
      end else begin
         instr_done     <= 1'b0;
         unsupported_op <= 1'b0;
         if (cycle_end) begin
            unique case (phase)
               saspe_ph_fetch: begin
                  if (is_pfx_x || is_pfx_y) begin
                     // A second prefix replaces the first
                     prefix <= is_pfx_y ? saspe_pfx_y : saspe_pfx_x;
                  end else if (is_push) begin
                     phase <= saspe_ph_push_hi;
                  end else if (is_pop || is_store) begin
                     phase <= saspe_ph_rd_lo;
                  end else begin
                     prefix         <= saspe_pfx_none;
                     instr_done     <= 1'b1;
                     unsupported_op <= !is_ldsp;
                  end
               end
               saspe_ph_rd_lo:   phase <= saspe_ph_rd_hi;
               saspe_ph_rd_hi: begin
                  if (is_store) begin
                     phase <= saspe_ph_st_lo;
                  end else begin
                     phase      <= saspe_ph_fetch;
                     prefix     <= saspe_pfx_none;
                     instr_done <= 1'b1;
                  end
               end
               saspe_ph_push_hi: phase <= saspe_ph_push_lo;
               saspe_ph_st_lo:   phase <= saspe_ph_st_hi;
               saspe_ph_push_lo,
               saspe_ph_st_hi: begin
                  phase      <= saspe_ph_fetch;
                  prefix     <= saspe_pfx_none;
                  instr_done <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // saspe_exec

/* verilog/saspe_pkg.sv */
// Constants shared by the stack and stack-pointer load sequencer.
// Assumes one clock; all timing is counted in clock states of that clock.
package saspe_pkg;

   // Opcode bytes
   localparam logic [7:0] SASPE_PFX_X      = 8'h00_DD;
   localparam logic [7:0] SASPE_PFX_Y      = 8'h00_FD;
   localparam logic [7:0] SASPE_OP_LDSP    = 8'h00_F9;
   localparam logic [7:0] SASPE_OP_STABS   = 8'h00_22;
   localparam logic [7:0] SASPE_PUSH_MASK  = 8'h00_CF;
   localparam logic [7:0] SASPE_PUSH_PAT   = 8'h00_C5;
   localparam logic [7:0] SASPE_POP_PAT    = 8'h00_C1;
   localparam int         SASPE_QQ_LSB     = 4;

   // Register file slots; push_pair_select maps onto the first four
   localparam logic [2:0] SASPE_SEL_COUNT  = 3'h0;
   localparam logic [2:0] SASPE_SEL_SECOND = 3'h1;
   localparam logic [2:0] SASPE_SEL_PTR    = 3'h2;
   localparam logic [2:0] SASPE_SEL_ACCF   = 3'h3;
   localparam logic [2:0] SASPE_SEL_IDX_X  = 3'h4;
   localparam logic [2:0] SASPE_SEL_IDX_Y  = 3'h5;
   localparam int         SASPE_NUM_REGS   = 6;

   // Clock states per machine cycle
   localparam logic [2:0] SASPE_T_FETCH    = 3'h4;
   localparam logic [2:0] SASPE_T_FETCH_PU = 3'h5;
   localparam logic [2:0] SASPE_T_FETCH_SP = 3'h6;
   localparam logic [2:0] SASPE_T_MEM      = 3'h3;
   // State index at which read data is taken
   localparam logic [2:0] SASPE_T_SAMPLE   = 3'h1;

   localparam logic [15:0] SASPE_ONE       = 16'h0001;
   localparam logic [15:0] SASPE_RST_WORD  = 16'h0000;

   typedef enum logic [1:0] {
      saspe_pfx_none,
      saspe_pfx_x,
      saspe_pfx_y
   } saspe_pfx_t;

   typedef enum logic [2:0] {
      saspe_ph_fetch,
      saspe_ph_rd_lo,
      saspe_ph_rd_hi,
      saspe_ph_push_hi,
      saspe_ph_push_lo,
      saspe_ph_st_lo,
      saspe_ph_st_hi
   } saspe_phase_t;

   typedef enum logic [1:0] {
      saspe_op_other,
      saspe_op_ldsp,
      saspe_op_push,
      saspe_op_pop
   } saspe_opk_t;

endpackage

/* verilog/saspe_regfile.sv */
// Register pairs of the CPU slice: six 16-bit words, one write port,
// two read ports whose data come out of registers (one cycle latency).
// Assumes the caller keeps the read selects stable while it needs data.
`timescale 1ns/10ps
module saspe_regfile
   import saspe_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = SASPE_NUM_REGS
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic             wr_en,
   input  wire logic [2:0]       wr_sel,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [2:0]       rd_sel,
   output logic      [WIDTH-1:0] rd_data,
   input  wire logic [2:0]       dbg_sel,
   output logic      [WIDTH-1:0] dbg_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_en && (int'(wr_sel) < DEPTH)) begin
         mem[wr_sel] <= wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data  <= '0;
         dbg_data <= '0;
      end else begin
         rd_data  <= (int'(rd_sel) < DEPTH) ? mem[rd_sel] : '0;
         dbg_data <= (int'(dbg_sel) < DEPTH) ? mem[dbg_sel] : '0;
      end
   end

endmodule // saspe_regfile
